// File: src/rtcca_pkg.sv
// Constants, register map and state layout of the real-time clock register block.
// Assumes a single 10 MHz core clock and a timing tick strobe from the crystal side.
package rtcca_pkg;

    // ========================================================================
    // Register map, word indices on the plain register port.
    // ========================================================================
    localparam int           ADDR_W        = 3;
    localparam logic [2:0]   OFF_CFG       = 3'h0;
    localparam logic [2:0]   OFF_PAD       = 3'h1;
    localparam logic [2:0]   OFF_ALCFG     = 3'h2;
    localparam logic [2:0]   OFF_AVAL      = 3'h3;
    localparam logic [2:0]   OFF_TVAL      = 3'h4;

    // ========================================================================
    // Field positions.
    // ========================================================================
    localparam int           CFG_EN_BIT    = 15;
    localparam int           CFG_WREN_BIT  = 13;
    localparam int           CFG_RIPL_BIT  = 12;
    localparam int           CFG_HALF_BIT  = 11;
    localparam int           CFG_OE_BIT    = 10;
    localparam int           PAD_SEL_BIT   = 1;
    localparam int           AL_EN_BIT     = 15;
    localparam int           AL_CHIME_BIT  = 14;

    // ========================================================================
    // Window pointer codes and mask codes.
    // ========================================================================
    localparam logic [1:0]   PTR_MINUTE_SECOND_PAIR    = 2'h0;
    localparam logic [1:0]   PTR_WDHR      = 2'h1;
    localparam logic [1:0]   PTR_MONDAY    = 2'h2;
    localparam logic [1:0]   PTR_YEAR      = 2'h3;
    localparam logic [3:0]   MASK_LAST     = 4'h9;

    // ========================================================================
    // Counts. The tick is one timing clock pulse of the 32.768 kHz crystal.
    // ========================================================================
    localparam int           TICKS_PER_SEC = 32768;
    localparam int           RIPPLE_TICKS  = 32;

    // ========================================================================
    // State of the block, registered as one word.
    // ========================================================================
    typedef struct packed {
        logic               en;
        logic               wren;
        logic               oe;
        logic [1:0]         tptr;
        logic [7:0]         cal;
        logic               sec_sel;
        logic               alm_en;
        logic               chime;
        logic [3:0]         alarm_period_mask;
        logic [1:0]         aptr;
        logic [7:0]         rpt;
        logic [6:0]         sec;
        logic [6:0]         min;
        logic [5:0]         hr;
        logic [2:0]         weekday_digit;
        logic [5:0]         day;
        logic [4:0]         mon;
        logic [7:0]         yr;
        logic [6:0]         asec;
        logic [6:0]         amin;
        logic [5:0]         ahr;
        logic [2:0]         awday;
        logic [5:0]         aday;
        logic [4:0]         amon;
        logic signed [16:0] presc;
        logic               half;
        logic               half_evt;
        logic               sec_evt;
        logic               alm_tog;
        logic               alm_evt;
        logic               pin;
        logic [15:0]        rdata;
    } rtcca_state_t;

    localparam rtcca_state_t RST_STATE = '{day: 6'h01, mon: 5'h01, aday: 6'h01,
                                           amon: 5'h01, default: '0};

endpackage

// File: src/rtcca_regs.sv
// Real-time clock and calendar: configuration, drift trim, alarm and time windows.
// Assumes tick is a one-cycle strobe per crystal pulse, synchronous to core_clk.
//
// How it works
// - Positive trim adds four pulses per minute each
// - Negative trim removes four pulses per minute each
// - Calibration register cleared only by power-on reset
// - Module enable written only while write enable set
// - Half-second bit read-only, cleared by seconds write
// - Select bit picks seconds clock or alarm pulse
// - Clock pin driven only while output enabled
// - Alarm disables itself when count zero, no chime
// - Repeat count decrements; chime wraps, otherwise holds
// - Count value is number of further repeats
// - Mask code selects the alarm period
// - Code nine yearly; reserved codes never fire
// - Alarm pointer selects alarm value pair
// - Alarm pointer decrements on high-byte access
// - Year is two BCD digits, high byte zero
// - Month tens bit twelve, units bits eleven-eight
// - Day tens bits five-four, units three-zero
// - Weekday bits ten-eight, hour digits below
// - Minute and second digit fields placement
// - Date and hour writes need write enable
// - Unimplemented bits read zero, ignore writes
// - Time pointer selects time value pair
// - Time pointer decrements on high-byte access
// - Time window writes blocked without write enable
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/10ps

module rtcca_regs
    import rtcca_pkg::*;
#(
    parameter int TICKS = rtcca_pkg::TICKS_PER_SEC
) (
    // Clock, power-on reset, other reset, freeze.
    input  logic                        core_clk,
    input  logic                        srst,
    input  logic                        sys_rst,
    input  logic                        clk_en,
    // Crystal timing pulse.
    input  logic                        tick,
    // Register port.
    input  logic [rtcca_pkg::ADDR_W-1:0] addr,
    input  logic [15:0]                 wdata,
    input  logic [1:0]                  wr_be,
    input  logic                        wr_stb,
    input  logic                        rd_stb,
    output logic [15:0]                 rdata,
    // Pin and event.
    output logic                        clock_out_pin,
    output logic                        alarm_event
);
    import rtcca_pkg::*;

    localparam logic signed [16:0] PRESC_LAST = 17'(TICKS - 1);
    localparam logic signed [16:0] HALF_PRE   = 17'(TICKS / 2 - 1);
    // A second shorter than the ripple span is flagged as ripple wherever the prescaler is not negative.
    localparam logic signed [16:0] RIPL_FROM  = (TICKS > RIPPLE_TICKS) ?
                                                17'(TICKS - RIPPLE_TICKS) : 17'sh00000;

    rtcca_state_t s_q;
    rtcca_state_t s_d;

    // ========================================================================
    // Helpers.
    // ========================================================================
    function automatic logic [7:0] bcd_next(input logic [7:0] v, input logic [7:0] last,
                                            input logic [7:0] first);
        if (v == last) begin
            bcd_next = first;
        end else if (v[3:0] == 4'h9) begin
            bcd_next = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_next = v + 8'h01;
        end
    endfunction

    function automatic logic [7:0] month_last(input logic [4:0] m, input logic [7:0] y);
        logic leap;
        leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                    : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
        case (m)
            5'h02:                      month_last = leap ? 8'h29 : 8'h28;
            5'h04, 5'h06, 5'h09, 5'h11: month_last = 8'h30;
            default:                    month_last = 8'h31;
        endcase
    endfunction

    function automatic logic [1:0] ptr_step(input logic [1:0] p);
        ptr_step = (p == 2'h0) ? 2'h0 : p - 2'h1;
    endfunction

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [1:0] be);
        merge = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
    endfunction

    // ========================================================================
    // Read images and alarm match.
    // ========================================================================
    logic        ripple;
    logic [15:0] cfg_img;
    logic [15:0] alcfg_img;
    logic [15:0] tval_img;
    logic [15:0] aval_img;
    logic        evt_any;
    logic        m_s1;
    logic        m_s;
    logic        m_m1;
    logic        m_m;
    logic        m_h;
    logic        m_w;
    logic        m_d;
    logic        m_mo;
    logic        alm_fire;

    assign ripple = s_q.en && ($signed(s_q.presc) >= RIPL_FROM);
    // Unimplemented positions are tied to zero in every image.
    assign cfg_img = {s_q.en, 1'b0, s_q.wren, ripple, s_q.half, s_q.oe, s_q.tptr, s_q.cal};
    assign alcfg_img = {s_q.alm_en, s_q.chime, s_q.alarm_period_mask, s_q.aptr, s_q.rpt};

    always_comb begin
        case (s_q.tptr)
            PTR_MINUTE_SECOND_PAIR: tval_img = {1'b0, s_q.min, 1'b0, s_q.sec};
            PTR_WDHR:   tval_img = {5'h00, s_q.weekday_digit, 2'h0, s_q.hr};
            PTR_MONDAY: tval_img = {3'h0, s_q.mon, 2'h0, s_q.day};
            default:    tval_img = {8'h00, s_q.yr};
        endcase
        case (s_q.aptr)
            PTR_MINUTE_SECOND_PAIR: aval_img = {1'b0, s_q.amin, 1'b0, s_q.asec};
            PTR_WDHR:   aval_img = {5'h00, s_q.awday, 2'h0, s_q.ahr};
            PTR_MONDAY: aval_img = {3'h0, s_q.amon, 2'h0, s_q.aday};
            default:    aval_img = 16'h0000;
        endcase
    end

    // The compare runs one cycle after the time has moved, on the settled value.
    assign evt_any = s_q.half_evt || s_q.sec_evt;
    assign m_s1    = s_q.sec[3:0] == s_q.asec[3:0];
    assign m_s     = s_q.sec == s_q.asec;
    assign m_m1    = s_q.min[3:0] == s_q.amin[3:0];
    assign m_m     = s_q.min == s_q.amin;
    assign m_h     = s_q.hr == s_q.ahr;
    assign m_w     = s_q.weekday_digit == s_q.awday;
    assign m_d     = s_q.day == s_q.aday;
    assign m_mo    = s_q.mon == s_q.amon;

    always_comb begin
        alm_fire = 1'b0;
        if (s_q.alm_en && evt_any) begin
            case (s_q.alarm_period_mask)
                4'h0:    alm_fire = 1'b1;
                4'h1:    alm_fire = s_q.sec_evt;
                4'h2:    alm_fire = s_q.sec_evt && m_s1;
                4'h3:    alm_fire = s_q.sec_evt && m_s;
                4'h4:    alm_fire = s_q.sec_evt && m_s && m_m1;
                4'h5:    alm_fire = s_q.sec_evt && m_s && m_m;
                4'h6:    alm_fire = s_q.sec_evt && m_s && m_m && m_h;
                4'h7:    alm_fire = s_q.sec_evt && m_s && m_m && m_h && m_w;
                4'h8:    alm_fire = s_q.sec_evt && m_s && m_m && m_h && m_d;
                // A 29 February alarm only matches in leap years.
                4'h9:    alm_fire = s_q.sec_evt && m_s && m_m && m_h && m_d && m_mo;
                default: alm_fire = 1'b0;
            endcase
        end
    end

    // ========================================================================
    // Next state.
    // ========================================================================
    logic        wr_cfg;
    logic        wr_pad;
    logic        wr_al;
    logic        wr_av;
    logic        wr_tv;
    logic [15:0] wm;

    assign wr_cfg = wr_stb && addr == OFF_CFG;
    assign wr_pad = wr_stb && addr == OFF_PAD;
    assign wr_al  = wr_stb && addr == OFF_ALCFG;
    assign wr_av  = wr_stb && addr == OFF_AVAL;
    assign wr_tv  = wr_stb && addr == OFF_TVAL;

    always_comb begin
        s_d          = s_q;
        s_d.rdata    = 16'h0000;
        s_d.alm_evt  = 1'b0;
        s_d.half_evt = 1'b0;
        s_d.sec_evt  = 1'b0;
        wm           = 16'h0000;

        // The other reset leaves the calibration register alone.
        if (sys_rst) begin
            s_d.sec_sel = 1'b0;
            s_d.alm_en  = 1'b0;
            s_d.chime   = 1'b0;
            s_d.alarm_period_mask   = 4'h0;
            s_d.aptr    = 2'h0;
            s_d.rpt     = 8'h00;
        end

        // Prescaler and calendar.
        if (s_q.en && tick) begin
            if ($signed(s_q.presc) >= PRESC_LAST) begin
                s_d.sec_evt = 1'b1;
                s_d.half    = 1'b0;
                s_d.presc   = 17'sh00000;
                s_d.sec     = 7'(bcd_next({1'b0, s_q.sec}, 8'h59, 8'h00));
                if (s_q.sec == 7'h59) begin
                    // Trim starts the new minute ahead or behind.
                    s_d.presc = {{7{s_q.cal[7]}}, s_q.cal, 2'b00};
                    s_d.min   = 7'(bcd_next({1'b0, s_q.min}, 8'h59, 8'h00));
                    if (s_q.min == 7'h59) begin
                        s_d.hr = 6'(bcd_next({2'h0, s_q.hr}, 8'h23, 8'h00));
                        if (s_q.hr == 6'h23) begin
                            s_d.weekday_digit = (s_q.weekday_digit >= 3'h6) ? 3'h0 : s_q.weekday_digit + 3'h1;
                            s_d.day  = 6'(bcd_next({2'h0, s_q.day},
                                                   month_last(s_q.mon, s_q.yr), 8'h01));
                            if ({2'h0, s_q.day} == month_last(s_q.mon, s_q.yr)) begin
                                s_d.mon = 5'(bcd_next({3'h0, s_q.mon}, 8'h12, 8'h01));
                                if (s_q.mon == 5'h12) begin
                                    s_d.yr = bcd_next(s_q.yr, 8'h99, 8'h00);
                                end
                            end
                        end
                    end
                end
            end else begin
                s_d.presc = s_q.presc + 17'sh00001;
                if (s_q.presc == HALF_PRE) begin
                    s_d.half     = 1'b1;
                    s_d.half_evt = 1'b1;
                end
            end
        end

        // Alarm event bookkeeping.
        if (alm_fire) begin
            s_d.alm_evt = 1'b1;
            s_d.alm_tog = ~s_q.alm_tog;
            // Count tells how many more firings remain.
            if (s_q.rpt != 8'h00 || s_q.chime) begin
                s_d.rpt = s_q.rpt - 8'h01;
            end
            if (s_q.rpt == 8'h00 && !s_q.chime) begin
                s_d.alm_en = 1'b0;
            end
        end

        // Register writes.
        if (wr_cfg) begin
            wm = merge(cfg_img, wdata, wr_be);
            if (s_q.wren) begin
                s_d.en = wm[CFG_EN_BIT];
            end
            s_d.wren = wm[CFG_WREN_BIT];
            s_d.oe   = wm[CFG_OE_BIT];
            s_d.tptr = wm[9:8];
            s_d.cal  = wm[7:0];
        end
        if (wr_pad) begin
            s_d.sec_sel = wdata[PAD_SEL_BIT] && wr_be[0];
        end
        if (wr_al) begin
            wm = merge(alcfg_img, wdata, wr_be);
            s_d.alm_en = wm[AL_EN_BIT];
            s_d.chime  = wm[AL_CHIME_BIT];
            s_d.alarm_period_mask  = wm[13:10];
            s_d.aptr   = wm[9:8];
            s_d.rpt    = wm[7:0];
        end
        if (wr_av) begin
            wm = merge(aval_img, wdata, wr_be);
            case (s_q.aptr)
                PTR_MINUTE_SECOND_PAIR: begin
                    s_d.amin = wm[14:8];
                    s_d.asec = wm[6:0];
                end
                PTR_WDHR: begin
                    s_d.awday = wm[10:8];
                    s_d.ahr   = wm[5:0];
                end
                PTR_MONDAY: begin
                    s_d.amon = wm[12:8];
                    s_d.aday = wm[5:0];
                end
                default: begin
                end
            endcase
            if (wr_be[1]) begin
                s_d.aptr = ptr_step(s_q.aptr);
            end
        end
        if (wr_tv) begin
            wm = merge(tval_img, wdata, wr_be);
            if (s_q.wren) begin
                case (s_q.tptr)
                    PTR_MINUTE_SECOND_PAIR: begin
                        s_d.min = wm[14:8];
                        s_d.sec = wm[6:0];
                        if (wr_be[0]) begin
                            s_d.presc = 17'sh00000;
                        end
                    end
                    PTR_WDHR: begin
                        s_d.weekday_digit = wm[10:8];
                        s_d.hr   = wm[5:0];
                    end
                    PTR_MONDAY: begin
                        s_d.mon = wm[12:8];
                        s_d.day = wm[5:0];
                    end
                    default: begin
                        s_d.yr = wm[7:0];
                    end
                endcase
            end
            // A half-second set in the same cycle still wins.
            if (wr_be[0] && s_q.tptr == PTR_MINUTE_SECOND_PAIR && !s_d.half_evt) begin
                s_d.half = 1'b0;
            end
            if (wr_be[1]) begin
                s_d.tptr = ptr_step(s_q.tptr);
            end
        end

        // Reads: the core reads a whole word, so any value window read steps that window's pointer.
        if (rd_stb) begin
            case (addr)
                OFF_CFG:   s_d.rdata = cfg_img;
                OFF_PAD:   s_d.rdata = {14'h0000, s_q.sec_sel, 1'b0};
                OFF_ALCFG: s_d.rdata = alcfg_img;
                OFF_AVAL: begin
                    s_d.rdata = aval_img;
                    s_d.aptr  = ptr_step(s_q.aptr);
                end
                OFF_TVAL: begin
                    s_d.rdata = tval_img;
                    s_d.tptr  = ptr_step(s_q.tptr);
                end
                default:   s_d.rdata = 16'h0000;
            endcase
        end

        // Pin source and gate.
        s_d.pin = s_q.oe && (s_q.sec_sel ? s_q.half : s_q.alm_tog);
    end

    // ========================================================================
    // State register. Only the power-on reset returns it to constants.
    // ========================================================================
    always_ff @(posedge core_clk) begin
        if (srst) begin
            s_q <= RST_STATE;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign rdata         = s_q.rdata;
    assign clock_out_pin = s_q.pin;
    assign alarm_event   = s_q.alm_evt;

    // ========================================================================
    // Checks.
    // ========================================================================
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);

    a_enable_lock: assert property (
        clk_en && wr_cfg && !s_q.wren |=> s_q.en == $past(s_q.en))
        else $error("module enable changed while writes locked");
    a_time_lock: assert property (
        clk_en && wr_tv && !s_q.wren && s_q.tptr == PTR_YEAR |=> s_q.yr == $past(s_q.yr))
        else $error("year changed while writes locked");
    a_half_clear: assert property (
        clk_en && wr_tv && wr_be[0] && s_q.tptr == PTR_MINUTE_SECOND_PAIR
        && !(s_q.en && tick && s_q.presc == HALF_PRE) |=> !s_q.half)
        else $error("half-second bit not cleared by seconds write");
    a_pin_gate: assert property (
        clk_en && !s_q.oe |=> !clock_out_pin)
        else $error("clock pin active with output disabled");
    a_pin_select: assert property (
        clk_en && s_q.oe && s_q.sec_sel |=> clock_out_pin == $past(s_q.half))
        else $error("clock pin does not follow seconds clock");
    a_alarm_stop: assert property (
        clk_en && alm_fire && s_q.rpt == 8'h00 && !s_q.chime && !wr_al && !sys_rst
        |=> !s_q.alm_en && s_q.rpt == 8'h00 && alarm_event)
        else $error("alarm not disabled after final event");
    a_chime_wrap: assert property (
        clk_en && alm_fire && s_q.rpt == 8'h00 && s_q.chime && !wr_al && !sys_rst
        |=> s_q.rpt == 8'hFF && s_q.alm_en)
        else $error("repeat count did not wrap with chime");
    a_reserved_mask: assert property (
        s_q.alarm_period_mask > MASK_LAST |-> !alm_fire)
        else $error("reserved mask code fired the alarm");
    a_tptr_step: assert property (
        clk_en && rd_stb && addr == OFF_TVAL
        |=> s_q.tptr == ptr_step($past(s_q.tptr)))
        else $error("time pointer did not step on reads");
    a_read_idle: assert property (
        clk_en && !rd_stb |=> rdata == 16'h0000)
        else $error("read data not idle outside a read");

    c_alarm_fire:  cover property (alarm_event && s_q.alm_en);
    c_chime_wrap:  cover property (alm_fire && s_q.rpt == 8'h00 && s_q.chime);
    c_minute_roll: cover property (s_q.sec_evt && s_q.sec == 7'h00);
    c_ptr_walk:    cover property (clk_en && wr_tv && wr_be[1] && s_q.tptr == PTR_YEAR);

endmodule

// File: tb/test_rtcca_regs.sv
// Self-checking bench for the clock register block, driven through its register port.
// Assumes the package map and a second shortened to eight ticks, one tick every two cycles.
`timescale 1ns/10ps

module test_rtcca_regs;
    import rtcca_pkg::*;

    logic              core_clk = 1'b0;
    logic              srst     = 1'b1;
    logic              sys_rst  = 1'b0;
    logic              clk_en   = 1'b1;
    logic              tick     = 1'b0;
    logic              tick_on  = 1'b0;
    logic [ADDR_W-1:0] addr     = '0;
    logic [15:0]       wdata    = '0;
    logic [1:0]        wr_be    = 2'h3;
    logic              wr_stb   = 1'b0;
    logic              rd_stb   = 1'b0;
    logic [15:0]       rdata;
    logic              clock_out_pin;
    logic              alarm_event;
    int                error_cnt   = 0;
    int                checks_done = 0;
    int                ev_cnt      = 0;
    int                pin_cnt     = 0;
    int                ev_base     = 0;
    logic [15:0]       tv_wr  [4]  = '{16'hFF99, 16'hF2F1, 16'hFEE3, 16'hD9D9};
    logic [15:0]       tv_exp [4]  = '{16'h0099, 16'h1231, 16'h0623, 16'h5959};
    logic [15:0]       av_exp [4]  = '{16'h0000, 16'h0229, 16'h0315, 16'h4530};

    rtcca_regs #(.TICKS(8)) i_rtcca_regs (.core_clk(core_clk), .srst(srst), .sys_rst(sys_rst),
        .clk_en(clk_en), .tick(tick), .addr(addr), .wdata(wdata), .wr_be(wr_be),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .clock_out_pin(clock_out_pin),
        .alarm_event(alarm_event));

    // ========================================================================
    // Clock, tick source and output monitors.
    // ========================================================================
    always #50 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        tick <= tick_on & ~tick;
        if (alarm_event === 1'b1) ev_cnt <= ev_cnt + 1;
        if (clock_out_pin === 1'b1) pin_cnt <= pin_cnt + 1;
    end

    // ========================================================================
    // Register port tasks.
    // ========================================================================
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
        @(posedge core_clk);
        wr_stb <= 1'b1;
        addr   <= a;
        wdata  <= d;
        @(posedge core_clk);
        wr_stb <= 1'b0;
    endtask

    // The mask hides status bits whose value depends on where the prescaler stands.
    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [15:0] m, input logic [15:0] e,
                       input string n);
        @(posedge core_clk);
        rd_stb <= 1'b1;
        addr   <= a;
        @(posedge core_clk);
        rd_stb <= 1'b0;
        #1;
        chk(n, e, rdata & m);
    endtask

    task automatic close_out();
        $display("Checks %0d, errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        #2000000;
        error_cnt++;
        close_out();
    end

    // ========================================================================
    // Test sequence.
    // ========================================================================
    initial begin
        repeat (3) @(posedge core_clk);
        srst <= 1'b0;
        rdc(OFF_CFG, 16'hFFFF, 16'h0000, "cfg reset");
        rdc(OFF_ALCFG, 16'hFFFF, 16'h0000, "alarm cfg reset");
        rdc(OFF_PAD, 16'hFFFF, 16'h0000, "pad reset");
        wr(3'h5, 16'hFFFF);
        rdc(3'h5, 16'hFFFF, 16'h0000, "unmapped");
        wr(OFF_CFG, 16'h8000);
        rdc(OFF_CFG, 16'hFFFF, 16'h0000, "locked enable");
        wr(OFF_CFG, 16'h2000);
        wr(OFF_CFG, 16'hE300);
        rdc(OFF_CFG, 16'hFFFF, 16'hB300, "enable and pointer");
        for (int i = 0; i < 4; i++) begin
            wr(OFF_TVAL, tv_wr[i]);
        end
        wr(OFF_CFG, 16'hA300);
        for (int i = 0; i < 4; i++) begin
            rdc(OFF_TVAL, 16'hFFFF, tv_exp[i], "time pair");
        end
        rdc(OFF_TVAL, 16'hFFFF, 16'h5959, "pointer floor");
        wr(OFF_CFG, 16'h8300);
        wr(OFF_TVAL, 16'h0011);
        wr(OFF_CFG, 16'h8300);
        rdc(OFF_TVAL, 16'hFFFF, 16'h0099, "locked year");
        rdc(OFF_CFG, 16'hFFFF, 16'h9200, "pointer step");
        wr(OFF_ALCFG, 16'h0200);
        wr(OFF_AVAL, 16'hE2E9);
        wr(OFF_AVAL, 16'h0315);
        wr(OFF_AVAL, 16'h4530);
        wr(OFF_ALCFG, 16'h0300);
        for (int i = 0; i < 4; i++) begin
            rdc(OFF_AVAL, 16'hFFFF, av_exp[i], "alarm pair");
        end
        // One repeat left means two alarms in all, then the alarm turns itself off.
        wr(OFF_ALCFG, 16'h8401);
        tick_on <= 1'b1;
        repeat (300) @(posedge core_clk);
        tick_on <= 1'b0;
        repeat (4) @(posedge core_clk);
        chk("alarm count", 16'h0002, 16'(ev_cnt));
        rdc(OFF_ALCFG, 16'hFFFF, 16'h0400, "alarm self clear");
        chk("pin gated", 16'h0000, 16'(pin_cnt));
        wr(OFF_CFG, 16'h8400);
        ev_base = ev_cnt;
        wr(OFF_ALCFG, 16'hC400);
        tick_on <= 1'b1;
        for (int i = 0; i < 100 && ev_cnt == ev_base; i++) begin
            @(posedge core_clk);
        end
        rdc(OFF_ALCFG, 16'hFFFF, 16'hC4FF, "chime wrap");
        tick_on <= 1'b0;
        repeat (4) @(posedge core_clk);
        chk("pin from alarm", 16'h0001, 16'(pin_cnt > 0));
        wr(OFF_PAD, 16'hFFFE);
        rdc(OFF_PAD, 16'hFFFF, 16'h0002, "pad select");
        clk_en <= 1'b0;
        wr(OFF_PAD, 16'h0000);
        clk_en <= 1'b1;
        rdc(OFF_PAD, 16'hFFFF, 16'h0002, "frozen write");
        @(posedge core_clk);
        sys_rst <= 1'b1;
        @(posedge core_clk);
        sys_rst <= 1'b0;
        rdc(OFF_CFG, 16'hE7FF, 16'h8400, "cfg kept");
        rdc(OFF_ALCFG, 16'hFFFF, 16'h0000, "alarm cfg cleared");
        rdc(OFF_PAD, 16'hFFFF, 16'h0000, "pad cleared");
        // Trim +1 shortens the new minute's first second to 4 ticks, trim -1 stretches it to 12.
        wr(OFF_CFG, 16'h2000);
        for (int i = 0; i < 2; i++) begin
            wr(OFF_TVAL, 16'h0059);
            wr(OFF_CFG, i ? 16'hA0FF : 16'hA001);
            tick_on <= 1'b1;
            repeat (i ? 36 : 28) @(posedge core_clk);
            tick_on <= 1'b0;
            rdc(OFF_TVAL, 16'hFFFF, i ? 16'h0100 : 16'h0101, "trimmed minute");
        end
        close_out();
    end

endmodule
